// ===== common/l2alt_map.svh
// Register offsets, field positions, reset values and limits of the table
`ifndef L2ALT_MAP_SVH
`define L2ALT_MAP_SVH

// ------------------------------
// Sizes
// ------------------------------
`define L2ALT_DEPTH        8192
`define L2ALT_NPORT        8
`define L2ALT_AW           8
`define L2ALT_STAMP_W      24
`define L2ALT_MAX_STATIC   7'h40

// ------------------------------
// Register byte offsets
// ------------------------------
`define L2ALT_CTRL         8'h00
`define L2ALT_AGE          8'h04
`define L2ALT_LEARN        8'h08
`define L2ALT_KVID         8'h0C
`define L2ALT_KMLO         8'h10
`define L2ALT_KMHI         8'h14
`define L2ALT_KPORTS       8'h18
`define L2ALT_CMD          8'h1C
`define L2ALT_STAT         8'h20
`define L2ALT_RVID         8'h24
`define L2ALT_RMLO         8'h28
`define L2ALT_RMHI         8'h2C
`define L2ALT_RPORTS       8'h30

// ------------------------------
// Field positions
// ------------------------------
`define L2ALT_CTRL_AGEDIS  0
`define L2ALT_CMD_ADD      0
`define L2ALT_CMD_DEL      1
`define L2ALT_CMD_NEXT     2
`define L2ALT_CMD_AFTER    3
`define L2ALT_STAT_BUSY    0
`define L2ALT_STAT_EOT     1
`define L2ALT_STAT_ERR     2
`define L2ALT_STAT_NSTAT   8
`define L2ALT_RVID_STATIC  16
`define L2ALT_RVID_VALID   17

// ------------------------------
// Age time in seconds
// ------------------------------
`define L2ALT_AGE_DEF      24'h00012C
`define L2ALT_AGE_MIN      32'h0000000A
`define L2ALT_AGE_MAX      32'h00989680

`endif

// ===== common/l2alt_pkg.sv
// Types shared by the address table modules
package l2alt_pkg;

  // ------------------------------
  // Scanner states
  // ------------------------------
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_FRAME = 6'h02,
    ST_ADD   = 6'h04,
    ST_DEL   = 6'h08,
    ST_NEXT  = 6'h10,
    ST_AGE   = 6'h20
  } l2alt_state_type;

  // ------------------------------
  // Per-port learning modes; the spare code acts as disabled
  // ------------------------------
  typedef enum logic [1:0] {
    MODE_AUTO   = 2'h0,
    MODE_OFF    = 2'h1,
    MODE_SECURE = 2'h2
  } l2alt_mode_type;

endpackage

// ===== logic/l2alt_learn_ctl.sv
// Per-port learning mode store with override by another function
`timescale 1ns/1ps
`include "l2alt_map.svh"

module l2alt_learn_ctl #(
  parameter int NPORT = `L2ALT_NPORT
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               wr_en,
  input  wire logic [2*NPORT-1:0] wr_data,
  input  wire logic [NPORT-1:0]   ovr_en,
  input  wire logic [2*NPORT-1:0] ovr_mode,
  output logic      [2*NPORT-1:0] mode_eff
);

  typedef struct packed {
    logic [2*NPORT-1:0] mode;
  } l2alt_lc_type;

  l2alt_lc_type q;
  l2alt_lc_type d;

  // ------------------------------
  // Next state
  // ------------------------------
  always_comb begin
    d = q;
    for (int p = 0; p < NPORT; p++) begin
      // Overridden ports keep their stored mode
      if (wr_en && !ovr_en[p]) begin
        d.mode[2*p +: 2] = wr_data[2*p +: 2];
      end
    end
  end

  always_comb begin
    for (int p = 0; p < NPORT; p++) begin
      mode_eff[2*p +: 2] = ovr_en[p] ? ovr_mode[2*p +: 2]
                                     : q.mode[2*p +: 2];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule // l2alt_learn_ctl

// ===== logic/l2alt_table.sv
// Layer-2 address table: lookup, learning, aging, static entries, walk
//
// Summary of operation
// - Destination address lookup picks egress ports
// - One table holds static and dynamic entries
// - Source address creates or refreshes dynamic entry
// - Unseen dynamic entries removed after age time
// - Age time 10 to 10000000 s, default 300
// - Control bit stops automatic aging
// - Auto mode learns unknown source at once
// - Disabled mode creates no dynamic entries
// - Secure mode admits only static sources
// - Override owns learning mode, blocks writes
// - Up to 64 static entries with ports
// - Table holds up to 8192 entries
// - Order is VLAN first, then address
// - Walk returns match or next entry
// - Walk past last entry flags end
// - Walk reports type, VLAN, address, ports
//
// The address map and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`include "l2alt_map.svh"

module l2alt_table #(
  parameter int DEPTH = `L2ALT_DEPTH,
  parameter int NPORT = `L2ALT_NPORT
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`L2ALT_AW-1:0]   paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   sec_tick,
  input  wire logic [NPORT-1:0]       ovr_en,
  input  wire logic [2*NPORT-1:0]     ovr_mode,
  input  wire logic                   frm_valid,
  output logic                        frm_ready,
  input  wire logic [$clog2(NPORT)-1:0] frm_rx_port,
  input  wire logic [11:0]            frm_vid,
  input  wire logic [47:0]            frm_dest_hw_addr,
  input  wire logic [47:0]            frm_src_hw_addr,
  input  wire logic [NPORT-1:0]       frm_vlan_ports,
  output logic                        fwd_valid,
  output logic                        fwd_drop,
  output logic      [NPORT-1:0]       fwd_ports
);

  localparam int IW = $clog2(DEPTH);
  localparam int PW = $clog2(NPORT);
  localparam int SW = `L2ALT_STAMP_W;

  typedef struct packed {
    logic              vld;
    logic              stat;
    logic [11:0]       vid;
    logic [47:0]       mac;
    logic [NPORT-1:0]  ports;
    logic [SW-1:0]     stamp;
  } l2alt_ent_type;

  typedef struct packed {
    l2alt_pkg::l2alt_state_type st;
    logic [IW-1:0]     idx;
    logic [SW-1:0]     now;
    logic              age_pend;
    logic              age_dis;
    logic [SW-1:0]     age_time;
    logic [11:0]       k_vid;
    logic [47:0]       k_mac;
    logic [NPORT-1:0]  k_ports;
    logic              k_after;
    logic [6:0]        n_static;
    logic              eot;
    logic              err;
    logic              hit_d;
    logic [NPORT-1:0]  dports;
    logic              hit_s;
    logic              s_stat;
    logic [IW-1:0]     s_idx;
    logic              fr;
    logic [IW-1:0]     f_idx;
    logic              best_v;
    logic [IW-1:0]     best_idx;
    logic [PW-1:0]     f_port;
    logic [11:0]       f_vid;
    logic [47:0]       f_dst;
    logic [47:0]       f_src;
    logic [NPORT-1:0]  f_vlan;
    logic              fwd_v;
    logic              fwd_drop;
    logic [NPORT-1:0]  fwd_ports;
    logic              res_vld;
    logic              res_stat;
    logic [11:0]       res_vid;
    logic [47:0]       res_mac;
    logic [NPORT-1:0]  res_ports;
    logic [31:0]       prdata;
  } l2alt_st_type;

  l2alt_st_type      q;
  l2alt_st_type      d;
  l2alt_ent_type     tab_q [DEPTH];
  logic              tw_en;
  logic [IW-1:0]     tw_idx;
  l2alt_ent_type     tw_ent;
  logic [2*NPORT-1:0] mode_eff;
  logic              acc;
  logic              wr;
  logic              cmd_w;
  logic              learn_w;

  // ------------------------------
  // Helpers
  // ------------------------------
  function automatic logic l2alt_hit(l2alt_ent_type e, logic [11:0] v,
                                     logic [47:0] m);
    return e.vld && e.vid == v && e.mac == m;
  endfunction

  function automatic logic l2alt_mapped(logic [`L2ALT_AW-1:0] a);
    return a[1:0] == 2'h0 && a <= `L2ALT_RPORTS;
  endfunction

  assign acc     = psel & penable;
  assign wr      = acc & pwrite;
  assign cmd_w   = wr && paddr == `L2ALT_CMD;
  assign learn_w = wr && paddr == `L2ALT_LEARN;

  l2alt_learn_ctl #(
    .NPORT (NPORT)
  ) u_learn (
    .pclk     (pclk),
    .presetn  (presetn),
    .wr_en    (learn_w),
    .wr_data  (pwdata[2*NPORT-1:0]),
    .ovr_en   (ovr_en),
    .ovr_mode (ovr_mode),
    .mode_eff (mode_eff)
  );

  // ------------------------------
  // Next state
  // ------------------------------
  always_comb begin
    l2alt_ent_type    e;
    logic             last;
    logic [1:0]       md;
    logic [NPORT-1:0] rxm;
    logic [59:0]      ek;
    logic [59:0]      kk;
    logic [59:0]      bk;
    e      = tab_q[q.idx];
    last   = q.idx == IW'(DEPTH - 1);
    md     = mode_eff[2*q.f_port +: 2];
    rxm    = NPORT'(1) << q.f_port;
    ek     = {e.vid, e.mac};
    kk     = {q.k_vid, q.k_mac};
    bk     = {tab_q[q.best_idx].vid, tab_q[q.best_idx].mac};
    d      = q;
    d.fwd_v = 1'b0;
    tw_en  = 1'b0;
    tw_idx = q.idx;
    tw_ent = e;

    if (wr) begin
      case (paddr)
        `L2ALT_CTRL:   d.age_dis = pwdata[`L2ALT_CTRL_AGEDIS];
        `L2ALT_AGE: begin
          // Out-of-range values are ignored
          if (pwdata >= `L2ALT_AGE_MIN && pwdata <= `L2ALT_AGE_MAX) begin
            d.age_time = pwdata[SW-1:0];
          end
        end
        `L2ALT_KVID:   d.k_vid = pwdata[11:0];
        `L2ALT_KMLO:   d.k_mac[31:0] = pwdata;
        `L2ALT_KMHI:   d.k_mac[47:32] = pwdata[15:0];
        `L2ALT_KPORTS: d.k_ports = pwdata[NPORT-1:0];
        default: ;
      endcase
    end

    if (psel && !penable && !pwrite) begin
      d.prdata = '0;
      case (paddr)
        `L2ALT_CTRL:   d.prdata[`L2ALT_CTRL_AGEDIS] = q.age_dis;
        `L2ALT_AGE:    d.prdata = 32'(q.age_time);
        `L2ALT_LEARN:  d.prdata = 32'(mode_eff);
        `L2ALT_KVID:   d.prdata = 32'(q.k_vid);
        `L2ALT_KMLO:   d.prdata = q.k_mac[31:0];
        `L2ALT_KMHI:   d.prdata = 32'(q.k_mac[47:32]);
        `L2ALT_KPORTS: d.prdata = 32'(q.k_ports);
        `L2ALT_STAT: begin
          d.prdata[`L2ALT_STAT_BUSY] = q.st != l2alt_pkg::ST_IDLE;
          d.prdata[`L2ALT_STAT_EOT]  = q.eot;
          d.prdata[`L2ALT_STAT_ERR]  = q.err;
          d.prdata[`L2ALT_STAT_NSTAT +: 7] = q.n_static;
        end
        `L2ALT_RVID: begin
          d.prdata[11:0] = q.res_vid;
          d.prdata[`L2ALT_RVID_STATIC] = q.res_stat;
          d.prdata[`L2ALT_RVID_VALID]  = q.res_vld;
        end
        `L2ALT_RMLO:   d.prdata = q.res_mac[31:0];
        `L2ALT_RMHI:   d.prdata = 32'(q.res_mac[47:32]);
        `L2ALT_RPORTS: d.prdata = 32'(q.res_ports);
        default: ;
      endcase
    end

    unique case (q.st)
      l2alt_pkg::ST_IDLE: begin
        d.idx    = '0;
        d.hit_d  = 1'b0;
        d.hit_s  = 1'b0;
        d.s_stat = 1'b0;
        d.fr     = 1'b0;
        d.best_v = 1'b0;
        // Commands first: an APB write is a one-cycle event
        if (cmd_w && pwdata[3:0] != 4'h0) begin
          d.eot     = 1'b0;
          d.err     = 1'b0;
          d.k_after = pwdata[`L2ALT_CMD_AFTER];
          if (pwdata[`L2ALT_CMD_ADD]) begin
            d.st = l2alt_pkg::ST_ADD;
          end else if (pwdata[`L2ALT_CMD_DEL]) begin
            d.st = l2alt_pkg::ST_DEL;
          end else if (pwdata[`L2ALT_CMD_NEXT]) begin
            d.st = l2alt_pkg::ST_NEXT;
          end
        end else if (q.age_pend) begin
          d.st       = l2alt_pkg::ST_AGE;
          d.age_pend = 1'b0;
        end else if (frm_valid && !cmd_w) begin
          d.st     = l2alt_pkg::ST_FRAME;
          d.f_port = frm_rx_port;
          d.f_vid  = frm_vid;
          d.f_dst  = frm_dest_hw_addr;
          d.f_src  = frm_src_hw_addr;
          d.f_vlan = frm_vlan_ports;
        end
      end
      l2alt_pkg::ST_FRAME: begin
        if (l2alt_hit(e, q.f_vid, q.f_dst)) begin
          d.hit_d  = 1'b1;
          d.dports = e.ports;
        end
        if (l2alt_hit(e, q.f_vid, q.f_src)) begin
          d.hit_s  = 1'b1;
          d.s_stat = e.stat;
          d.s_idx  = q.idx;
        end
        if (!e.vld && !q.fr) begin
          d.fr    = 1'b1;
          d.f_idx = q.idx;
        end
        if (last) begin
          d.st       = l2alt_pkg::ST_IDLE;
          d.fwd_v    = 1'b1;
          d.fwd_drop = md == l2alt_pkg::MODE_SECURE && !d.s_stat;
          if (d.fwd_drop) begin
            d.fwd_ports = '0;
          end else if (d.hit_d) begin
            d.fwd_ports = d.dports;
          end else begin
            d.fwd_ports = q.f_vlan & ~rxm;
          end
          // Only auto mode learns; static sources are never moved
          if (md == l2alt_pkg::MODE_AUTO && !d.s_stat) begin
            if (d.hit_s) begin
              tw_en        = 1'b1;
              tw_idx       = d.s_idx;
              tw_ent       = tab_q[d.s_idx];
              tw_ent.ports = rxm;
              tw_ent.stamp = q.now;
            end else if (d.fr) begin
              tw_en  = 1'b1;
              tw_idx = d.f_idx;
              tw_ent = '{vld: 1'b1, stat: 1'b0, vid: q.f_vid,
                         mac: q.f_src, ports: rxm, stamp: q.now};
            end
          end
        end
      end
      l2alt_pkg::ST_ADD: begin
        if (l2alt_hit(e, q.k_vid, q.k_mac)) begin
          d.hit_s  = 1'b1;
          d.s_stat = e.stat;
          d.s_idx  = q.idx;
        end
        if (!e.vld && !q.fr) begin
          d.fr    = 1'b1;
          d.f_idx = q.idx;
        end
        if (last) begin
          d.st = l2alt_pkg::ST_IDLE;
          if (d.hit_s && d.s_stat) begin
            tw_en        = 1'b1;
            tw_idx       = d.s_idx;
            tw_ent       = tab_q[d.s_idx];
            tw_ent.ports = q.k_ports;
          end else if (q.n_static == `L2ALT_MAX_STATIC) begin
            d.err = 1'b1;
          end else if (d.hit_s || d.fr) begin
            // A dynamic entry with the same key turns static
            tw_en      = 1'b1;
            tw_idx     = d.hit_s ? d.s_idx : d.f_idx;
            tw_ent     = '{vld: 1'b1, stat: 1'b1, vid: q.k_vid,
                           mac: q.k_mac, ports: q.k_ports, stamp: q.now};
            d.n_static = q.n_static + 7'h01;
          end else begin
            d.err = 1'b1;
          end
        end
      end
      l2alt_pkg::ST_DEL: begin
        if (l2alt_hit(e, q.k_vid, q.k_mac) && e.stat) begin
          d.hit_s = 1'b1;
          d.s_idx = q.idx;
        end
        if (last) begin
          d.st = l2alt_pkg::ST_IDLE;
          if (d.hit_s) begin
            tw_en      = 1'b1;
            tw_idx     = d.s_idx;
            tw_ent     = tab_q[d.s_idx];
            tw_ent.vld = 1'b0;
            d.n_static = q.n_static - 7'h01;
          end else begin
            d.err = 1'b1;
          end
        end
      end
      l2alt_pkg::ST_NEXT: begin
        // Key compare puts VLAN above address
        if (e.vld && (q.k_after ? ek > kk : ek >= kk) &&
            (!q.best_v || ek < bk)) begin
          d.best_v   = 1'b1;
          d.best_idx = q.idx;
        end
        if (last) begin
          d.st      = l2alt_pkg::ST_IDLE;
          d.res_vld = d.best_v;
          d.eot     = !d.best_v;
          if (d.best_v) begin
            d.res_stat  = tab_q[d.best_idx].stat;
            d.res_vid   = tab_q[d.best_idx].vid;
            d.res_mac   = tab_q[d.best_idx].mac;
            d.res_ports = tab_q[d.best_idx].ports;
          end
        end
      end
      l2alt_pkg::ST_AGE: begin
        // Modulo stamp difference; valid while age time fits the stamp
        if (e.vld && !e.stat && !q.age_dis &&
            SW'(q.now - e.stamp) >= q.age_time) begin
          tw_en      = 1'b1;
          tw_ent.vld = 1'b0;
        end
        if (last) begin
          d.st = l2alt_pkg::ST_IDLE;
        end
      end
      default: d.st = l2alt_pkg::ST_IDLE;
    endcase

    if (q.st != l2alt_pkg::ST_IDLE && !last) begin
      d.idx = q.idx + IW'(1);
    end
    if (sec_tick) begin
      d.now = q.now + SW'(1);
      if (!q.age_dis) begin
        d.age_pend = 1'b1;
      end
    end
  end

  // ------------------------------
  // Registers and table storage
  // ------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q          <= '0;
      q.st       <= l2alt_pkg::ST_IDLE;
      q.age_time <= `L2ALT_AGE_DEF;
    end else begin
      q <= d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        tab_q[i] <= '0;
      end
    end else if (tw_en) begin
      tab_q[tw_idx] <= tw_ent;
    end
  end

  // ------------------------------
  // Outputs
  // ------------------------------
  assign pready    = 1'b1;
  assign pslverr   = acc & !l2alt_mapped(paddr);
  assign prdata    = q.prdata;
  assign frm_ready = q.st == l2alt_pkg::ST_IDLE && !cmd_w && !q.age_pend;
  assign fwd_valid = q.fwd_v;
  assign fwd_drop  = q.fwd_drop;
  assign fwd_ports = q.fwd_ports;

endmodule // l2alt_table

// ===== dv/l2alt_table_checker.sv
// Checker of the address table port behaviour
`timescale 1ns/1ps
`include "l2alt_map.svh"
module l2alt_table_checker #(
  parameter int DEPTH = 16,
  parameter int NPORT = 8
) (
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [`L2ALT_AW-1:0] paddr,
  input wire logic [31:0]          prdata,
  input wire logic [NPORT-1:0]     ovr_en,
  input wire logic [2*NPORT-1:0]   ovr_mode,
  input wire logic                 frm_valid,
  input wire logic                 frm_ready,
  input wire logic                 fwd_valid,
  input wire logic                 fwd_drop,
  input wire logic [NPORT-1:0]     fwd_ports
);
  // ------------------------------
  // Helpers
  // ------------------------------
  localparam int LAT = DEPTH + 1;
  logic [2*NPORT-1:0] ov_mask;
  logic               rd_acc;
  always_comb begin
    for (int p = 0; p < NPORT; p++) begin
      ov_mask[2*p+:2] = {2{ovr_en[p]}};
    end
  end
  assign rd_acc = psel && penable && !pwrite;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ------------------------------
  // Properties
  // ------------------------------
  a_fwd_latency: assert property (
    frm_valid && frm_ready |-> ##LAT fwd_valid)
    else $error("result not at fixed latency");
  a_scan_quiet: assert property (
    frm_valid && frm_ready |=> (!frm_ready && !fwd_valid) [*8])
    else $error("early result or second take");
  a_fwd_pulse: assert property (
    fwd_valid |=> !fwd_valid) else $error("result pulse too long");
  a_ports_hold: assert property (
    !fwd_valid |-> $stable(fwd_ports) && $stable(fwd_drop))
    else $error("result changed without pulse");
  a_drop_empty: assert property (
    fwd_valid && fwd_drop |-> fwd_ports == '0)
    else $error("dropped frame has ports");
  a_cmd_blocks: assert property (
    psel && penable && pwrite && paddr == `L2ALT_CMD |-> !frm_ready)
    else $error("frame taken during command write");
  a_age_range: assert property (
    rd_acc && paddr == `L2ALT_AGE |->
      prdata >= `L2ALT_AGE_MIN && prdata <= `L2ALT_AGE_MAX)
    else $error("age time out of range");
  a_learn_ovr: assert property (
    rd_acc && paddr == `L2ALT_LEARN |->
      ((prdata[2*NPORT-1:0] ^ ovr_mode) & ov_mask) == '0)
    else $error("override mode not shown");
  c_drop: cover property (fwd_valid && fwd_drop);
  c_fwd: cover property (fwd_valid && !fwd_drop);
  c_cmd: cover property (psel && penable && pwrite && paddr == `L2ALT_CMD);
endmodule // l2alt_table_checker

bind l2alt_table l2alt_table_checker #(.DEPTH(DEPTH), .NPORT(NPORT)) i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .ovr_en(ovr_en),
  .ovr_mode(ovr_mode), .frm_valid(frm_valid), .frm_ready(frm_ready),
  .fwd_valid(fwd_valid), .fwd_drop(fwd_drop), .fwd_ports(fwd_ports));

// ===== dv/l2alt_port_model.sv
// Frame ingress pipeline model feeding the address table
`timescale 1ns/1ps
module l2alt_port_model (
  input  wire logic pclk,
  input  wire logic frm_ready,
  input  wire logic fwd_valid,
  output logic        frm_valid,
  output logic [2:0]  frm_rx_port,
  output logic [11:0] frm_vid,
  output logic [47:0] frm_dest_hw_addr,
  output logic [47:0] frm_src_hw_addr,
  output logic [7:0]  frm_vlan_ports
);
  initial begin
    {frm_valid, frm_rx_port, frm_vid} = '0;
    {frm_dest_hw_addr, frm_src_hw_addr, frm_vlan_ports} = '0;
  end
  // ------------------------------
  // One frame, held until taken, then wait for the result
  // ------------------------------
  task automatic send(input logic [2:0] rx, input logic [11:0] v,
      input logic [47:0] d, s, input logic [7:0] vm, output logic ok);
    int k;
    @(posedge pclk);
    frm_valid <= 1'b1;
    {frm_rx_port, frm_vid, frm_dest_hw_addr} <= {rx, v, d};
    {frm_src_hw_addr, frm_vlan_ports} <= {s, vm};
    k = 0;
    // Ready judged settled, before the edge that takes the frame
    do begin
      @(negedge pclk);
      k++;
    end while (frm_ready !== 1'b1 && k < 200);
    @(posedge pclk);
    // Released lines carry junk so a late latch shows up
    frm_valid <= 1'b0;
    {frm_rx_port, frm_vid, frm_dest_hw_addr} <= ~{rx, v, d};
    {frm_src_hw_addr, frm_vlan_ports} <= ~{s, vm};
    do begin
      @(negedge pclk);
      k++;
    end while (fwd_valid !== 1'b1 && k < 400);
    ok = (k < 400);
  endtask
endmodule // l2alt_port_model

// ===== dv/tb_l2_address_learning_table.sv
// Self-checking bench for the layer-2 address table
`timescale 1ns/1ps
`include "l2alt_map.svh"
module tb_l2_address_learning_table;
  localparam int DEPTH = 16;
  localparam logic [47:0] MA = 48'h0A01;
  localparam logic [47:0] MB = 48'h0B01;
  localparam logic [47:0] MC = 48'h0C01;
  localparam logic [47:0] MG = 48'h0F01;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        sec_tick, err, frm_valid, frm_ready, fwd_valid, fwd_drop;
  logic [7:0]  paddr, ovr_en, fwd_ports, frm_vlan_ports, vp;
  logic [15:0] ovr_mode;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  frm_rx_port;
  logic [11:0] frm_vid;
  logic [47:0] frm_dest_hw_addr, frm_src_hw_addr, sa, da;
  logic [47:0] w_mac [3] = '{MA, MC, MG};
  logic [31:0] w_vid [3] = '{32'h00020005, 32'h00030005, 32'h00020005};
  logic [7:0]  w_prt [3] = '{8'h02, 8'h30, 8'h04};
  int          mismatches, n_tests, seed, i;

  l2alt_table #(.DEPTH(DEPTH), .NPORT(8)) i_dut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sec_tick(sec_tick), .ovr_en(ovr_en),
    .ovr_mode(ovr_mode), .frm_valid(frm_valid), .frm_ready(frm_ready),
    .frm_rx_port(frm_rx_port), .frm_vid(frm_vid),
    .frm_dest_hw_addr(frm_dest_hw_addr), .frm_src_hw_addr(frm_src_hw_addr),
    .frm_vlan_ports(frm_vlan_ports), .fwd_valid(fwd_valid),
    .fwd_drop(fwd_drop), .fwd_ports(fwd_ports));
  l2alt_port_model i_pm (.pclk(pclk), .frm_ready(frm_ready),
    .fwd_valid(fwd_valid), .frm_valid(frm_valid), .frm_rx_port(frm_rx_port),
    .frm_vid(frm_vid), .frm_dest_hw_addr(frm_dest_hw_addr),
    .frm_src_hw_addr(frm_src_hw_addr), .frm_vlan_ports(frm_vlan_ports));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // ------------------------------
  // Bus, frame and compare tasks
  // ------------------------------
  function automatic logic [7:0] flood(input logic [7:0] vm, input int rx);
    return vm & ~(8'h01 << rx);
  endfunction
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk_reg(input logic [7:0] a, input logic [31:0] e,
      input logic ee = 1'b0);
    apb(1'b0, a, 32'h0);
    n_tests++;
    if (rd !== e || err !== ee) begin
      mismatches++;
      $display("BAD %0t reg %h got %h/%b exp %h", $time, a, rd, err, e);
    end
  endtask
  task automatic cmd(input logic [31:0] c);
    int k;
    apb(1'b1, `L2ALT_CMD, c);
    k = 0;
    do begin
      apb(1'b0, `L2ALT_STAT, 32'h0);
      k++;
    end while (rd[0] !== 1'b0 && k < 40);
  endtask
  task automatic key(input logic [11:0] v, input logic [47:0] m,
      input logic [7:0] p);
    apb(1'b1, `L2ALT_KVID, {20'h0, v});
    apb(1'b1, `L2ALT_KMLO, m[31:0]);
    apb(1'b1, `L2ALT_KMHI, {16'h0, m[47:32]});
    apb(1'b1, `L2ALT_KPORTS, {24'h0, p});
  endtask
  task automatic frame(input logic [2:0] rx, input logic [11:0] v,
      input logic [47:0] d, s, input logic [7:0] vm, ep, input logic ed);
    logic ok;
    i_pm.send(rx, v, d, s, vm, ok);
    n_tests++;
    if (ok !== 1'b1 || fwd_ports !== ep || fwd_drop !== ed) begin
      mismatches++;
      $display("BAD %0t fwd got %h/%b exp %h/%b", $time, fwd_ports,
        fwd_drop, ep, ed);
    end
  endtask
  // Ticks spaced so each aging sweep finishes before the next
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge pclk);
      sec_tick <= 1'b1;
      @(posedge pclk);
      sec_tick <= 1'b0;
      repeat (DEPTH + 4) @(posedge pclk);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    $display("BAD %0t timeout", $time);
    give_verdict;
  end
  // ------------------------------
  // Scenarios
  // ------------------------------
  initial begin
    seed = 32'ha1db;
    {psel, penable, pwrite, sec_tick, presetn} = 5'h00;
    {paddr, pwdata, ovr_en, ovr_mode} = 64'h0;
    mismatches = 0;
    n_tests = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    chk_reg(`L2ALT_AGE, 32'h0000012C);
    chk_reg(`L2ALT_CTRL, 32'h00000000);
    chk_reg(`L2ALT_LEARN, 32'h00000000);
    chk_reg(`L2ALT_STAT, 32'h00000000);
    chk_reg(8'h34, 32'h00000000, 1'b1);
    apb(1'b1, `L2ALT_AGE, 32'h00000009);
    chk_reg(`L2ALT_AGE, 32'h0000012C);
    apb(1'b1, `L2ALT_AGE, 32'h00989681);
    chk_reg(`L2ALT_AGE, 32'h0000012C);
    apb(1'b1, `L2ALT_AGE, 32'h00989680);
    chk_reg(`L2ALT_AGE, 32'h00989680);
    apb(1'b1, `L2ALT_AGE, 32'h0000000A);
    chk_reg(`L2ALT_AGE, 32'h0000000A);
    $display("test registers done");
    frame(3'h1, 12'h005, MB, MA, 8'hFF, 8'hFD, 1'b0);
    frame(3'h2, 12'h005, MA, MG, 8'hFF, 8'h02, 1'b0);
    key(12'h005, MC, 8'h30);
    cmd(32'h1);
    chk_reg(`L2ALT_STAT, 32'h00000100);
    frame(3'h2, 12'h005, MC, MG, 8'hFF, 8'h30, 1'b0);
    $display("test lookup done");
    key(12'h005, 48'h0, 8'h00);
    cmd(32'h4);
    for (i = 0; i < 3; i++) begin
      chk_reg(`L2ALT_RVID, w_vid[i]);
      chk_reg(`L2ALT_RMLO, w_mac[i][31:0]);
      chk_reg(`L2ALT_RPORTS, {24'h0, w_prt[i]});
      key(12'h005, w_mac[i], 8'h00);
      cmd(32'hC);
    end
    chk_reg(`L2ALT_STAT, 32'h00000102);
    $display("test walk done");
    ovr_mode <= 16'h0800;
    ovr_en <= 8'h20;
    apb(1'b1, `L2ALT_LEARN, 32'h00000240);
    chk_reg(`L2ALT_LEARN, 32'h00000A40);
    sa = 48'h1;
    for (i = 0; i < 8; i++) begin
      vp = 8'($random(seed));
      da = sa;
      sa = {16'h0, 32'($random(seed))};
      frame(3'h3, 12'h007, da, sa, vp, flood(vp, 3), 1'b0);
    end
    frame(3'h4, 12'h005, MA, MC, 8'hFF, 8'h02, 1'b0);
    frame(3'h4, 12'h005, MA, 48'h0D01, 8'hFF, 8'h00, 1'b1);
    frame(3'h5, 12'h005, MA, 48'h0E01, 8'hFF, 8'h00, 1'b1);
    apb(1'b1, `L2ALT_LEARN, 32'h00000000);
    chk_reg(`L2ALT_LEARN, 32'h00000800);
    ovr_en <= 8'h00;
    chk_reg(`L2ALT_LEARN, 32'h00000000);
    $display("test modes done");
    key(12'h005, MC, 8'h00);
    cmd(32'h2);
    chk_reg(`L2ALT_STAT, 32'h00000000);
    cmd(32'h2);
    chk_reg(`L2ALT_STAT, 32'h00000004);
    $display("test delete done");
    apb(1'b1, `L2ALT_CTRL, 32'h00000001);
    tick(12);
    frame(3'h2, 12'h005, MA, MG, 8'hFF, 8'h02, 1'b0);
    apb(1'b1, `L2ALT_CTRL, 32'h00000000);
    frame(3'h1, 12'h005, MB, MA, 8'hFF, 8'hFD, 1'b0);
    tick(9);
    frame(3'h2, 12'h005, MA, MG, 8'hFF, 8'h02, 1'b0);
    tick(2);
    frame(3'h2, 12'h005, MA, MG, 8'hFF, 8'hFB, 1'b0);
    $display("test aging done");
    give_verdict;
  end
endmodule // tb_l2_address_learning_table
